// *** core/sstg_pkg.sv ***
// constants for the scan sensor timing generator
package sstg_pkg;
  // ==========================================
  // register word indexes (byte address = index * 4)
  localparam logic [29:0] IDX_AUX_EDGES = 30'h01ff88a2;
  localparam logic [29:0] IDX_AUX_EDGES_HI = 30'h01ff88a3;
  localparam logic [29:0] IDX_SMP_EDGES = 30'h01ff88a4;
  localparam logic [29:0] IDX_SMP_MODE = 30'h01ff88a5;
  localparam logic [29:0] IDX_CLAMP_LEN = 30'h01ff88a6;
  localparam logic [29:0] IDX_CLAMP_CTL = 30'h01ff88a7;
  localparam logic [29:0] IDX_SKIP_LO = 30'h01ff88a8;
  localparam logic [29:0] IDX_SKIP_HI = 30'h01ff88a9;
  localparam logic [29:0] IDX_CLAMP_EDGES = 30'h01ff88aa;
  localparam logic [29:0] IDX_CLAMP_EDGES_HI = 30'h01ff88ab;
  localparam logic [29:0] IDX_SCAN_CTRL = 30'h01ff88b0;
  localparam logic [29:0] IDX_LEAD_IN = 30'h01ff88b1;
  localparam logic [29:0] IDX_LINE_LAST = 30'h01ff88b2;
  localparam logic [29:0] IDX_STATUS = 30'h01ff88b3;
  // ==========================================
  // field positions
  localparam int FALL_LSB = 4;
  localparam int RISE_LSB = 0;
  localparam int MODE_BIT = 7;
  localparam int METHOD_BIT = 7;
  localparam int INT_EN_BIT = 6;
  localparam int EXT_EN_BIT = 5;
  localparam int EXT_GB_BIT = 4;
  localparam int EXT_INV_BIT = 3;
  localparam int ORIGIN_BIT = 7;
  localparam int SCAN_BIT = 0;
  localparam int DIV_LSB = 4;
  localparam int DELAY_LSB = 8;
  localparam int SHIFT_BIT = 10;
  // ==========================================
  // reset values
  localparam logic [7:0] EDGES_RST = 8'h00;
  localparam logic [13:0] COUNT_RST = 14'h0000;
  localparam logic [4:0] CLAMP_CTL_RST = 5'h00;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [2:0] SHD_RST = 3'h0;
endpackage : sstg_pkg

// *** core/sstg_timing_gen.sv ***
// dot-period timing generator: aux clock c, sample strobe and clamp outputs
//
// Notes on behaviour
// - aux clock c falls at divider count in edge bits 7-4.
// - aux clock c rises at divider count in edge bits 3-0.
// - strobe mode 0 runs while scanning; mode 1 only on valid pixels.
// - strobe mode never changes the count of data-capture pulses.
// - sample strobe falls at divider count in bits 7-4.
// - sample strobe rises at divider count in bits 3-0.
// - clamp method bit: 1 line-based window, 0 pixel-based.
// - line-based window lasts the seven-bit window length in dots.
// - pixel-based clamp runs in every dot of the scanline.
// - internal and external clamp share one shift and delay setting.
// - origin bit 1 counts skip dots from scanline start, lead-in included.
// - origin bit 0 counts skip dots from the first valid pixel.
// - window starts after the fourteen-bit skip count of dots.
// - origin 0: line ending before skip is done gives no clamp.
// - origin 1: lead-in shorter than skip gives no clamp at all.
// - origin and skip only matter for line-based clamping.
// - clamp wave falls at divider count in clamp edge bits 7-4.
// - clamp wave rises at divider count in clamp edge bits 3-0.
`timescale 1ns/1ps
module sstg_timing_gen
  import sstg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic guardband_active,
  output logic aux_clock_c,
  output logic sample_strobe,
  output logic clamp_int,
  output logic clamp_ext,
  output logic pixel_capture
);

  // ==========================================
  // state
  typedef struct packed {
    logic [7:0] aux_edges;
    logic [7:0] smp_edges;
    logic smp_mode;
    logic [6:0] win_dots;
    logic [4:0] clamp_ctl;
    logic [13:0] skip_dots;
    logic origin;
    logic [7:0] clamp_edges;
    logic scan_active;
    logic [3:0] div_last;
    logic [2:0] shd;
    logic [13:0] lead_in;
    logic [13:0] line_last;
    logic [3:0] sub;
    logic [13:0] dot;
    logic aux;
    logic smp;
    logic cw;
    logic [3:0] dly;
    logic cl_int;
    logic cl_ext;
    logic cap;
    logic [31:0] rdata;
    logic err;
  } sstg_state_s;

  sstg_state_s s;
  sstg_state_s next_s;

  // per-dot wave: fall wins when both counts match
  // counts past div_last never match, so such an edge never happens
  function automatic logic edge_wave(input logic cur, input logic [3:0] sub,
                                     input logic [7:0] edges);
    if (sub == edges[FALL_LSB +: 4]) begin
      return 1'b0;
    end else if (sub == edges[RISE_LSB +: 4]) begin
      return 1'b1;
    end
    return cur;
  endfunction : edge_wave

  // address decode of the word index
  function automatic logic mapped(input logic [29:0] idx);
    return (idx >= IDX_AUX_EDGES && idx <= IDX_CLAMP_EDGES_HI) ||
           (idx >= IDX_SCAN_CTRL && idx <= IDX_STATUS);
  endfunction : mapped

  logic dot_end;
  logic valid_dot;
  logic [14:0] ref_dot;
  logic [14:0] win_end;
  logic line_win;
  logic clamp_sel;
  logic [4:0] taps;
  logic [2:0] tap_sel;
  logic picked;
  logic wr;
  logic [29:0] idx;

  // ==========================================
  // dot timing and clamp window
  always_comb begin
    dot_end = (s.sub == s.div_last);
    // lead-in dots are scanned but carry no pixel data
    valid_dot = s.scan_active && (s.dot >= s.lead_in);
    // origin picks where the skip count starts
    if (s.origin) begin
      ref_dot = {1'b0, s.dot};
    end else begin
      ref_dot = {1'b0, s.dot} - {1'b0, s.lead_in};
    end
    // one bit wider so skip plus length cannot wrap
    win_end = 15'({1'b0, s.skip_dots} + {8'h00, s.win_dots});
    // origin 1 needs the skip inside the lead-in, origin 0 only valid dots
    line_win = s.scan_active && ref_dot >= {1'b0, s.skip_dots}
               && ref_dot < win_end
               && (s.origin ? (s.lead_in >= s.skip_dots) : valid_dot);
    // method selects window or whole line; origin/skip unused otherwise
    if (s.clamp_ctl[4]) begin
      clamp_sel = s.cw && line_win;
    end else begin
      clamp_sel = s.cw && s.scan_active;
    end
    // one shared shift/delay tap for both clamp outputs
    // tap 0 is the undelayed select; the two-bit delay adds 0 to 3 stages and shift adds one
    taps = {s.dly, clamp_sel};
    tap_sel = {1'b0, s.shd[1:0]} + {2'b00, s.shd[2]};
    picked = taps[tap_sel];
  end

  // ==========================================
  // apb decode
  assign idx = paddr[31:2];
  assign wr = psel && penable && pwrite;
  // zero wait states: each access completes at its first access edge
  assign pready = 1'b1;
  assign prdata = s.rdata;
  assign pslverr = s.err && psel && penable;

  // ==========================================
  // next state
  always_comb begin
    next_s = s;
    // register writes in the access phase
    if (wr) begin
      // reserved high bytes and status fall to the default and are dropped
      case (idx)
        IDX_AUX_EDGES: next_s.aux_edges = pwdata[7:0];
        IDX_SMP_EDGES: next_s.smp_edges = pwdata[7:0];
        IDX_SMP_MODE: next_s.smp_mode = pwdata[MODE_BIT];
        IDX_CLAMP_LEN: next_s.win_dots = pwdata[6:0];
        IDX_CLAMP_CTL: next_s.clamp_ctl = pwdata[METHOD_BIT:EXT_INV_BIT];
        IDX_SKIP_LO: next_s.skip_dots[7:0] = pwdata[7:0];
        IDX_SKIP_HI: begin
          next_s.skip_dots[13:8] = pwdata[5:0];
          next_s.origin = pwdata[ORIGIN_BIT];
        end
        IDX_CLAMP_EDGES: next_s.clamp_edges = pwdata[7:0];
        IDX_SCAN_CTRL: begin
          next_s.scan_active = pwdata[SCAN_BIT];
          next_s.div_last = pwdata[DIV_LSB +: 4];
          next_s.shd = pwdata[SHIFT_BIT:DELAY_LSB];
        end
        IDX_LEAD_IN: next_s.lead_in = pwdata[13:0];
        IDX_LINE_LAST: next_s.line_last = pwdata[13:0];
        default: next_s.err = s.err;
      endcase
    end
    // read data and error captured in the setup phase
    // latching at setup lets both stand unchanged through the access
    if (psel && !penable) begin
      next_s.err = !mapped(idx);
      next_s.rdata = 32'h00000000;
      if (idx == IDX_STATUS) begin
        next_s.rdata = {12'h000, s.cl_ext, s.cl_int, valid_dot, s.scan_active, 2'b00, s.dot};
      end else if (idx == IDX_SCAN_CTRL) begin
        next_s.rdata = {21'h0, s.shd, s.div_last, 3'b000, s.scan_active};
      end
    end
    // divider and dot counters
    // stopping the scan parks both counters, so a restart begins at dot 0
    if (!s.scan_active) begin
      next_s.sub = 4'h0;
      next_s.dot = COUNT_RST;
    end else if (dot_end) begin
      next_s.sub = 4'h0;
      next_s.dot = (s.dot == s.line_last) ? COUNT_RST : 14'(s.dot + 14'h0001);
    end else begin
      next_s.sub = 4'(s.sub + 4'h1);
    end
    // per-dot waves
    // scan_active gates every wave, so each starts low after a restart
    next_s.aux = s.scan_active && edge_wave(s.aux, s.sub, s.aux_edges);
    if (s.smp_mode) begin
      next_s.smp = valid_dot && edge_wave(s.smp, s.sub, s.smp_edges);
    end else begin
      next_s.smp = s.scan_active && edge_wave(s.smp, s.sub, s.smp_edges);
    end
    next_s.cw = s.scan_active && edge_wave(s.cw, s.sub, s.clamp_edges);
    // one capture pulse per valid dot whatever the strobe mode
    next_s.cap = valid_dot && dot_end;
    // shared delay line and clamp gating
    // guardband holds the last external level rather than forcing it low
    next_s.dly = taps[3:0];
    next_s.cl_int = s.clamp_ctl[3] && picked;
    if (!(s.clamp_ctl[1] && guardband_active)) begin
      next_s.cl_ext = (s.clamp_ctl[2] && picked) ^ s.clamp_ctl[0];
    end
  end

  // ==========================================
  // state register
  // the async reset clears every field, which also stops the scan
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign aux_clock_c = s.aux;
  assign sample_strobe = s.smp;
  assign clamp_int = s.cl_int;
  assign clamp_ext = s.cl_ext;
  assign pixel_capture = s.cap;

  // ==========================================
  // checks
  // each property looks at the registered value one edge after the decision
  property p_aux_fall;
    @(posedge ref_clk) disable iff (!resetn)
      s.sub == s.aux_edges[7:4] && !wr |=> !aux_clock_c;
  endproperty
  a_aux_fall: assert property (p_aux_fall) else $error("aux clock c missed fall");

  property p_aux_rise;
    @(posedge ref_clk) disable iff (!resetn)
      s.scan_active && s.sub == s.aux_edges[3:0] && s.aux_edges[3:0] != s.aux_edges[7:4]
      |=> aux_clock_c;
  endproperty
  a_aux_rise: assert property (p_aux_rise) else $error("aux clock c missed rise");

  property p_smp_fall;
    @(posedge ref_clk) disable iff (!resetn)
      s.sub == s.smp_edges[7:4] |=> !sample_strobe;
  endproperty
  a_smp_fall: assert property (p_smp_fall) else $error("strobe missed fall");

  property p_smp_rise;
    @(posedge ref_clk) disable iff (!resetn)
      !s.smp_mode && s.scan_active && s.sub == s.smp_edges[3:0]
      && s.smp_edges[3:0] != s.smp_edges[7:4] |=> sample_strobe;
  endproperty
  a_smp_rise: assert property (p_smp_rise) else $error("strobe missed rise");

  property p_smp_valid_only;
    @(posedge ref_clk) disable iff (!resetn)
      s.smp_mode && !valid_dot |=> !sample_strobe;
  endproperty
  a_smp_valid_only: assert property (p_smp_valid_only) else $error("strobe outside pixels");

  property p_capture;
    @(posedge ref_clk) disable iff (!resetn)
      pixel_capture |-> $past(valid_dot) && $past(s.sub) == $past(s.div_last);
  endproperty
  a_capture: assert property (p_capture) else $error("capture pulse misplaced");

  // six quiet select cycles flush the deepest tap and the output flop
  property p_no_clamp_short_lead;
    @(posedge ref_clk) disable iff (!resetn)
      (s.clamp_ctl[4] && s.origin && s.lead_in < s.skip_dots) [*6] |-> !clamp_int;
  endproperty
  a_no_clamp_short_lead: assert property (p_no_clamp_short_lead) else $error("clamp on short lead");

  property p_pixel_clamp;
    @(posedge ref_clk) disable iff (!resetn)
      !s.clamp_ctl[4] && s.clamp_ctl[3] && s.shd == 3'b000 && s.cw && s.scan_active
      |=> clamp_int;
  endproperty
  a_pixel_clamp: assert property (p_pixel_clamp) else $error("pixel clamp missing");

  property p_int_gate;
    @(posedge ref_clk) disable iff (!resetn)
      !s.clamp_ctl[3] |=> !clamp_int;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("internal clamp not gated");

  property p_ext_freeze;
    @(posedge ref_clk) disable iff (!resetn)
      s.clamp_ctl[1] && guardband_active |=> $stable(clamp_ext);
  endproperty
  a_ext_freeze: assert property (p_ext_freeze) else $error("external clamp moved in guardband");

  // disabled external clamp shows only the invert level
  property p_ext_gate;
    @(posedge ref_clk) disable iff (!resetn)
      !s.clamp_ctl[2] && !(s.clamp_ctl[1] && guardband_active)
      |=> clamp_ext == $past(s.clamp_ctl[0]);
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("external clamp not gated");

  // stopped scan drives no aux clock c, no strobe and no capture
  property p_idle_low;
    @(posedge ref_clk) disable iff (!resetn)
      !s.scan_active |=> !aux_clock_c && !sample_strobe && !pixel_capture;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("wave while scan stopped");

  // at most one capture per dot
  property p_capture_single;
    @(posedge ref_clk) disable iff (!resetn)
      pixel_capture && s.div_last != 4'h0 |=> !pixel_capture;
  endproperty
  a_capture_single: assert property (p_capture_single) else $error("double capture");

  // clamp wave edges inside the dot
  property p_clamp_fall;
    @(posedge ref_clk) disable iff (!resetn)
      s.sub == s.clamp_edges[7:4] |=> !s.cw;
  endproperty
  a_clamp_fall: assert property (p_clamp_fall) else $error("clamp wave missed fall");

  property p_clamp_rise;
    @(posedge ref_clk) disable iff (!resetn)
      s.scan_active && s.sub == s.clamp_edges[3:0]
      && s.clamp_edges[3:0] != s.clamp_edges[7:4] |=> s.cw;
  endproperty
  a_clamp_rise: assert property (p_clamp_rise) else $error("clamp wave missed rise");

  c_line_clamp: cover property (@(posedge ref_clk) disable iff (!resetn)
    s.clamp_ctl[4] && clamp_int);
  c_valid_strobe: cover property (@(posedge ref_clk) disable iff (!resetn)
    s.smp_mode && sample_strobe);
  c_line_wrap: cover property (@(posedge ref_clk) disable iff (!resetn)
    s.scan_active && dot_end && s.dot == s.line_last);
  c_short_lead: cover property (@(posedge ref_clk) disable iff (!resetn)
    s.clamp_ctl[4] && s.origin && s.lead_in < s.skip_dots);

endmodule : sstg_timing_gen

// *** tb/sstg_afe_model.sv ***
// sensor and converter model that counts the waves it receives
`timescale 1ns/1ps
module sstg_afe_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic aux_clock_c,
  input wire logic sample_strobe,
  input wire logic clamp_int,
  input wire logic clamp_ext,
  input wire logic pixel_capture,
  output logic [31:0] n_aux,
  output logic [31:0] n_smp,
  output logic [31:0] n_ci,
  output logic [31:0] n_ce,
  output logic [31:0] n_cap
);
  // ==========================================
  // high cycles of each wave and stored words
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {n_aux, n_smp, n_ci, n_ce, n_cap} <= '0;
    end else begin
      n_aux <= n_aux + 32'(aux_clock_c);
      n_smp <= n_smp + 32'(sample_strobe);
      n_ci <= n_ci + 32'(clamp_int);
      n_ce <= n_ce + 32'(clamp_ext);
      n_cap <= n_cap + 32'(pixel_capture);
    end
  end
endmodule : sstg_afe_model

// *** tb/tb_top.sv ***
// self-checking bench for the scan sensor timing generator
`timescale 1ns/1ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin error_cnt++; \
  $display("BAD %0t got %0h exp %0h", $time, g, x); end end
module tb_top;
  import sstg_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic guardband_active = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, r;
  logic pready, pslverr, e, aux_clock_c, sample_strobe, clamp_int, clamp_ext, pixel_capture;
  logic [31:0] n_aux, n_smp, n_ci, n_ce, n_cap, a0, s0, i0, x0, p0;
  int error_cnt = 0, compares = 0;
  int d, L, M, ar, wa, sr, ws, cr, wc, len, skip, lc, wn;
  logic [7:0] ctl;
  logic [31:0] sc;
  logic org, mode, gb;
  sstg_timing_gen uut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .guardband_active(guardband_active), .aux_clock_c(aux_clock_c),
    .sample_strobe(sample_strobe), .clamp_int(clamp_int), .clamp_ext(clamp_ext),
    .pixel_capture(pixel_capture));
  sstg_afe_model afe (.ref_clk(ref_clk), .resetn(resetn), .aux_clock_c(aux_clock_c),
    .sample_strobe(sample_strobe), .clamp_int(clamp_int), .clamp_ext(clamp_ext),
    .pixel_capture(pixel_capture), .n_aux(n_aux), .n_smp(n_smp), .n_ci(n_ci), .n_ce(n_ce),
    .n_cap(n_cap));
  // ==========================================
  // clock and hang guard
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    end_of_test();
  end
  task automatic end_of_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // ==========================================
  // apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [29:0] idx, input logic [31:0] v);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= v;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      error_cnt++;
      end_of_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] ed(int rs, int w);
    return 32'((rs + w) * 16 + rs);
  endfunction : ed
  // clamp window dots per line
  function automatic int win();
    int v = M + 1 - L;
    if (!ctl[7]) return M + 1;
    if (!org) return (v <= skip) ? 0 : ((v - skip > len) ? len : v - skip);
    if (L < skip) return 0;
    return (M + 1 - skip > len) ? len : M + 1 - skip;
  endfunction : win
  function automatic int exp_ext(int b);
    if (ctl[4] && gb) return ctl[3] ? lc : 0;
    b = ctl[5] ? b : 0;
    return ctl[3] ? lc - b : b;
  endfunction : exp_ext
  task automatic pick();
    d = 1 + $urandom % 6;
    ar = $urandom % d;
    wa = 1 + $urandom % (d - ar);
    sr = $urandom % d;
    ws = 1 + $urandom % (d - sr);
    cr = $urandom % d;
    wc = 1 + $urandom % (d - cr);
    L = $urandom % 4;
    M = L + 2 + $urandom % 5;
    len = 1 + $urandom % 6;
    skip = $urandom % 8;
    org = 1'($urandom);
    mode = 1'($urandom);
    ctl = 8'($urandom) & 8'hf8;
    gb = 1'($urandom);
    sc = {21'h0, 3'($urandom), 4'(d), 4'h1};
  endtask : pick
  // ==========================================
  // program one setup and count a whole line of waves
  task automatic run();
    lc = (M + 1) * (d + 1);
    apb(1'b1, IDX_SCAN_CTRL, 32'h0);
    guardband_active <= 1'b0;
    apb(1'b1, IDX_CLAMP_CTL, 32'(ctl));
    apb(1'b1, IDX_AUX_EDGES, ed(ar, wa));
    apb(1'b1, IDX_SMP_EDGES, ed(sr, ws));
    apb(1'b1, IDX_SMP_MODE, {24'h0, mode, 7'h0});
    apb(1'b1, IDX_CLAMP_LEN, 32'(len));
    apb(1'b1, IDX_SKIP_LO, 32'(skip));
    apb(1'b1, IDX_SKIP_HI, {24'h0, org, 7'h0});
    apb(1'b1, IDX_CLAMP_EDGES, ed(cr, wc));
    apb(1'b1, IDX_LEAD_IN, 32'(L));
    apb(1'b1, IDX_LINE_LAST, 32'(M));
    guardband_active <= gb;
    apb(1'b1, IDX_SCAN_CTRL, sc);
    repeat (2 * lc) @(posedge ref_clk);
    {a0, s0, i0, x0, p0} = {n_aux, n_smp, n_ci, n_ce, n_cap};
    repeat (lc) @(posedge ref_clk);
    wn = win() * wc;
    `CHK(n_aux - a0, 32'((M + 1) * wa))
    `CHK(n_smp - s0, 32'((mode ? M + 1 - L : M + 1) * ws))
    `CHK(n_cap - p0, 32'(M + 1 - L))
    `CHK(n_ci - i0, 32'(ctl[6] ? wn : 0))
    `CHK(n_ce - x0, 32'(exp_ext(wn)))
    apb(1'b0, IDX_SCAN_CTRL, 32'h0);
    `CHK(r, sc)
    apb(1'b0, IDX_STATUS, 32'h0);
    `CHK({e, r[16], r[13:0] <= 14'(M)}, 3'b011)
    `CHK(r[17], r[13:0] >= 14'(L))
  endtask : run
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h65b2400c));
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    `CHK({aux_clock_c, sample_strobe, clamp_int, clamp_ext, pixel_capture}, 5'h0)
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, IDX_AUX_EDGES + 30'(i), 32'h0);
      `CHK({e, r}, 33'h0)
    end
    apb(1'b1, IDX_AUX_EDGES_HI, 32'hff);
    `CHK(e, 1'b0)
    apb(1'b1, 30'h01ff88c0, 32'hff);
    `CHK(e, 1'b1)
    pick();
    ctl = 8'he0;
    org = 1'b0;
    skip = M + 1 - L;
    run();
    pick();
    ctl = 8'he8;
    org = 1'b1;
    skip = L + 1;
    run();
    pick();
    ctl = 8'h68;
    skip = 15;
    sc[10:8] = 3'h0;
    run();
    pick();
    ctl = 8'hf0;
    gb = 1'b1;
    run();
    for (int i = 0; i < 12; i++) begin
      pick();
      run();
    end
    end_of_test();
  end
endmodule : tb_top
